// ==== hw/mie_pkg.sv ====
// constants and types shared by the instruction execute block
// ****************************************************************
// Overview of operation
// - bcd adjust writes acc plus correction to memory, only carry
// - add six per nibble above nine or carry
// - decrement memory, zero flag; acc form keeps memory
// - increment memory, zero flag; acc form keeps memory
// - halt: stop clock, clear watchdog, set sleep flag
// - jump loads address, two cycles, no flags
// - copy ops move data without touching flags
// - idle op only advances program counter
// - or ops update only zero flag
// - subroutine exit reloads pc from stack
// - immediate form of subroutine exit also loads immediate into acc
// - interrupt exit reloads pc, sets irq enable
// - rotate left, bit seven into bit zero
// - rotate left through carry
// - rotate right, bit zero into bit seven
// - rotate right through carry
// - subtract with borrow sets ov z ac c
// - decrement skip zero skips with dummy cycle
// - acc form stores result in acc, skips
// - untaken skip completes in one cycle
// ****************************************************************
package mie_pkg;

    localparam int DATA_W = 8;
    localparam int PC_W   = 13;

    localparam logic [7:0] ADJ_LO   = 8'h06;
    localparam logic [7:0] ADJ_HI   = 8'h60;
    localparam logic [3:0] NIB_MAX  = 4'h9;
    localparam logic [7:0] ONE      = 8'h01;
    localparam logic [7:0] ZERO     = 8'h00;

    // flag positions inside the status byte
    localparam int FLAG_C  = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    typedef enum logic [4:0] {
        OP_IDLE       = 5'h00,
        OP_BCD_ADJ    = 5'h01,
        OP_DEC_M      = 5'h02,
        OP_DEC_A      = 5'h03,
        OP_INC_M      = 5'h04,
        OP_INC_A      = 5'h05,
        OP_HALT       = 5'h06,
        OP_JUMP       = 5'h07,
        OP_MOV_AM     = 5'h08,
        OP_MOV_AX     = 5'h09,
        OP_MOV_MA     = 5'h0a,
        OP_OR_AM      = 5'h0b,
        OP_OR_AX      = 5'h0c,
        OP_OR_MM      = 5'h0d,
        OP_RET        = 5'h0e,
        OP_RET_AX     = 5'h0f,
        OP_INTERRUPT_EXIT       = 5'h10,
        OP_ROL_M      = 5'h11,
        OP_ROL_A      = 5'h12,
        OP_ROLC_M     = 5'h13,
        OP_ROLC_A     = 5'h14,
        OP_ROR_M      = 5'h15,
        OP_ROR_A      = 5'h16,
        OP_RORC_M     = 5'h17,
        OP_RORC_A     = 5'h18,
        OP_SBC_A      = 5'h19,
        OP_SBC_M      = 5'h1a,
        OP_DSZ_M      = 5'h1b,
        OP_DSZ_A      = 5'h1c
    } mie_op_e;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_DUMMY = 2'b01,
        ST_SLEEP = 2'b11
    } mie_state_e;

endpackage : mie_pkg

// ==== hw/mie_alu.sv ====
// combinational datapath for the execute block
`timescale 1ns/10ps
module mie_alu
(
    // operands
    input  wire logic [7:0]      acc_i,
    input  wire logic [7:0]      mem_i,
    input  wire logic [7:0]      imm_i,
    input  wire logic [3:0]      flags_i,
    input  wire mie_pkg::mie_op_e op_i,
    // results
    output logic      [7:0]      res_o,
    output logic      [3:0]      flags_o
);

    logic [8:0] diff;
    logic [4:0] ldiff;
    logic       nb;
    logic [7:0] adj;
    logic [8:0] bsum;
    logic       cin;

    always_comb
    begin
        cin   = flags_i[mie_pkg::FLAG_C];
        nb    = ~cin;
        res_o = acc_i;
        flags_o = flags_i;
        diff  = 9'h000;
        ldiff = 5'h00;
        adj   = mie_pkg::ZERO;
        bsum  = 9'h000;
        unique case (op_i)
            mie_pkg::OP_BCD_ADJ:
            begin
                // two nibble corrections, carry kept or set
                if (acc_i[3:0] > mie_pkg::NIB_MAX
                    || flags_i[mie_pkg::FLAG_AC])
                    adj = adj | mie_pkg::ADJ_LO;
                if (acc_i[7:4] > mie_pkg::NIB_MAX
                    || flags_i[mie_pkg::FLAG_C])
                    adj = adj | mie_pkg::ADJ_HI;
                bsum = {1'b0, acc_i} + {1'b0, adj};
                res_o = bsum[7:0];
                flags_o[mie_pkg::FLAG_C] = cin | bsum[8];
            end
            mie_pkg::OP_DEC_M, mie_pkg::OP_DEC_A:
            begin
                res_o = mem_i - mie_pkg::ONE;
                flags_o[mie_pkg::FLAG_Z] = (res_o == mie_pkg::ZERO);
            end
            mie_pkg::OP_INC_M, mie_pkg::OP_INC_A:
            begin
                res_o = mem_i + mie_pkg::ONE;
                flags_o[mie_pkg::FLAG_Z] = (res_o == mie_pkg::ZERO);
            end
            mie_pkg::OP_MOV_AM, mie_pkg::OP_MOV_MA:
                res_o = (op_i == mie_pkg::OP_MOV_AM) ? mem_i : acc_i;
            mie_pkg::OP_MOV_AX, mie_pkg::OP_RET_AX:
                res_o = imm_i;
            mie_pkg::OP_OR_AM, mie_pkg::OP_OR_MM, mie_pkg::OP_OR_AX:
            begin
                res_o = acc_i | ((op_i == mie_pkg::OP_OR_AX) ? imm_i
                                                            : mem_i);
                flags_o[mie_pkg::FLAG_Z] = (res_o == mie_pkg::ZERO);
            end
            mie_pkg::OP_ROL_M, mie_pkg::OP_ROL_A:
                res_o = {mem_i[6:0], mem_i[7]};
            mie_pkg::OP_ROLC_M, mie_pkg::OP_ROLC_A:
            begin
                res_o = {mem_i[6:0], cin};
                flags_o[mie_pkg::FLAG_C] = mem_i[7];
            end
            mie_pkg::OP_ROR_M, mie_pkg::OP_ROR_A:
                res_o = {mem_i[0], mem_i[7:1]};
            mie_pkg::OP_RORC_M, mie_pkg::OP_RORC_A:
            begin
                res_o = {cin, mem_i[7:1]};
                flags_o[mie_pkg::FLAG_C] = mem_i[0];
            end
            mie_pkg::OP_SBC_A, mie_pkg::OP_SBC_M:
            begin
                // borrow out clears carry
                diff  = {1'b0, acc_i} - {1'b0, mem_i} - {8'h00, nb};
                ldiff = {1'b0, acc_i[3:0]} - {1'b0, mem_i[3:0]}
                        - {4'h0, nb};
                res_o = diff[7:0];
                flags_o[mie_pkg::FLAG_C]  = ~diff[8];
                flags_o[mie_pkg::FLAG_AC] = ~ldiff[4];
                flags_o[mie_pkg::FLAG_Z]  = (diff[7:0] == mie_pkg::ZERO);
                flags_o[mie_pkg::FLAG_OV] = (acc_i[7] != mem_i[7])
                                            && (diff[7] != acc_i[7]);
            end
            mie_pkg::OP_DSZ_M, mie_pkg::OP_DSZ_A:
                res_o = mem_i - mie_pkg::ONE;
            default:
                res_o = acc_i;
        endcase
    end

endmodule : mie_alu

// ==== hw/mie_execute.sv ====
// execute stage: accumulator, flags, pc and power control
`timescale 1ns/10ps
module mie_execute
#(
    parameter int PC_W = mie_pkg::PC_W
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // instruction
    input  wire logic             valid_i,
    input  wire mie_pkg::mie_op_e op_i,
    input  wire logic [7:0]       imm_i,
    input  wire logic [PC_W-1:0]  addr_i,
    // data memory and stack
    input  wire logic [7:0]       mem_rd_i,
    input  wire logic [PC_W-1:0]  stack_top_i,
    input  wire logic             irq_pending_i,
    input  wire logic             wake_i,
    // results
    output logic      [7:0]       acc_o,
    output logic      [3:0]       flags_o,
    output logic      [7:0]       mem_wd_o,
    output logic                  mem_we_o,
    output logic      [PC_W-1:0]  pc_o,
    output logic                  stack_pop_o,
    output logic                  busy_o,
    output logic                  irq_enable_o,
    output logic                  irq_enter_o,
    output logic                  sleep_flag_o,
    output logic                  wdt_timeout_flag_o,
    output logic                  wdt_clear_o,
    output logic                  clk_stop_o
);

    // ****************************************************************
    // datapath
    // ****************************************************************
    logic [7:0] acc_reg;
    logic [3:0] flags_reg;
    logic [7:0] alu_res;
    logic [3:0] alu_flags;
    logic [PC_W-1:0] pc_reg;
    logic       take;
    logic       skip;
    logic       skip_hold;
    mie_pkg::mie_state_e state_reg;

    mie_alu u_alu
    (
        .acc_i   (acc_reg),
        .mem_i   (mem_rd_i),
        .imm_i   (imm_i),
        .flags_i (flags_reg),
        .op_i    (op_i),
        .res_o   (alu_res),
        .flags_o (alu_flags)
    );

    function automatic logic to_acc(input mie_pkg::mie_op_e op);
        to_acc = op inside {mie_pkg::OP_DEC_A, mie_pkg::OP_INC_A,
                 mie_pkg::OP_MOV_AM, mie_pkg::OP_MOV_AX,
                 mie_pkg::OP_OR_AM, mie_pkg::OP_OR_AX, mie_pkg::OP_RET_AX,
                 mie_pkg::OP_ROL_A, mie_pkg::OP_ROLC_A, mie_pkg::OP_ROR_A,
                 mie_pkg::OP_RORC_A, mie_pkg::OP_SBC_A, mie_pkg::OP_DSZ_A};
    endfunction : to_acc

    function automatic logic to_mem(input mie_pkg::mie_op_e op);
        to_mem = op inside {mie_pkg::OP_BCD_ADJ, mie_pkg::OP_DEC_M,
                 mie_pkg::OP_INC_M, mie_pkg::OP_MOV_MA, mie_pkg::OP_OR_MM,
                 mie_pkg::OP_ROL_M, mie_pkg::OP_ROLC_M, mie_pkg::OP_ROR_M,
                 mie_pkg::OP_RORC_M, mie_pkg::OP_SBC_M, mie_pkg::OP_DSZ_M};
    endfunction : to_mem

    assign take = valid_i && (state_reg == mie_pkg::ST_RUN);
    assign skip = (op_i == mie_pkg::OP_DSZ_M || op_i == mie_pkg::OP_DSZ_A)
                  && (alu_res == mie_pkg::ZERO);

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            state_reg <= mie_pkg::ST_RUN;
        else
        begin
            unique case (state_reg)
                mie_pkg::ST_RUN:
                    if (take)
                    begin
                        if (op_i == mie_pkg::OP_HALT)
                            state_reg <= mie_pkg::ST_SLEEP;
                        else if (skip
                                 || op_i inside {mie_pkg::OP_JUMP,
                                 mie_pkg::OP_RET, mie_pkg::OP_RET_AX,
                                 mie_pkg::OP_INTERRUPT_EXIT})
                            state_reg <= mie_pkg::ST_DUMMY;
                    end
                mie_pkg::ST_DUMMY:
                    state_reg <= mie_pkg::ST_RUN;
                mie_pkg::ST_SLEEP:
                    if (wake_i)
                        state_reg <= mie_pkg::ST_RUN;
                default:
                    state_reg <= mie_pkg::ST_RUN;
            endcase
        end
    end

    // ****************************************************************
    // accumulator and flags
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            acc_reg   <= mie_pkg::ZERO;
            flags_reg <= mie_pkg::FLAGS_RST;
        end
        else if (take)
        begin
            if (to_acc(op_i))
                acc_reg <= alu_res;
            flags_reg <= alu_flags;
        end
    end

    // ****************************************************************
    // memory write
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mem_we_o <= 1'b0;
            mem_wd_o <= mie_pkg::ZERO;
        end
        else
        begin
            mem_we_o <= take && to_mem(op_i);
            mem_wd_o <= alu_res;
        end
    end

    // ****************************************************************
    // program counter and stack
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pc_reg      <= '0;
            stack_pop_o <= 1'b0;
            irq_enter_o <= 1'b0;
        end
        else
        begin
            stack_pop_o <= take && op_i inside {mie_pkg::OP_RET,
                           mie_pkg::OP_RET_AX, mie_pkg::OP_INTERRUPT_EXIT};
            irq_enter_o <= take && op_i == mie_pkg::OP_INTERRUPT_EXIT
                           && irq_pending_i;
            if (take)
            begin
                unique case (op_i)
                    mie_pkg::OP_JUMP:
                        pc_reg <= addr_i;
                    mie_pkg::OP_RET, mie_pkg::OP_RET_AX, mie_pkg::OP_INTERRUPT_EXIT:
                        pc_reg <= stack_top_i;
                    mie_pkg::OP_HALT:
                        pc_reg <= pc_reg;
                    default:
                        pc_reg <= pc_reg + PC_W'(1);
                endcase
            end
            else if (state_reg == mie_pkg::ST_DUMMY && skip_hold)
                pc_reg <= pc_reg + PC_W'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            skip_hold <= 1'b0;
        else
            skip_hold <= take && skip;
    end

    // ****************************************************************
    // power and interrupt control
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            irq_enable_o       <= 1'b0;
            sleep_flag_o       <= 1'b0;
            wdt_timeout_flag_o <= 1'b0;
            wdt_clear_o        <= 1'b0;
            clk_stop_o         <= 1'b0;
        end
        else
        begin
            wdt_clear_o <= take && op_i == mie_pkg::OP_HALT;
            if (take && op_i == mie_pkg::OP_INTERRUPT_EXIT)
                irq_enable_o <= 1'b1;
            if (take && op_i == mie_pkg::OP_HALT)
            begin
                sleep_flag_o       <= 1'b1;
                wdt_timeout_flag_o <= 1'b0;
                clk_stop_o         <= 1'b1;
            end
            else if (state_reg == mie_pkg::ST_SLEEP && wake_i)
                clk_stop_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            busy_o <= 1'b0;
        else
            busy_o <= take && (skip || op_i inside {mie_pkg::OP_JUMP,
                      mie_pkg::OP_RET, mie_pkg::OP_RET_AX,
                      mie_pkg::OP_INTERRUPT_EXIT, mie_pkg::OP_HALT});
    end

    assign acc_o   = acc_reg;
    assign flags_o = flags_reg;
    assign pc_o    = pc_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking exec_cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_jump_taken;
        take && op_i == mie_pkg::OP_JUMP;
    endsequence

    jump_two_cycle_a: assert property (
        s_jump_taken |=> state_reg == mie_pkg::ST_DUMMY ##1
        state_reg == mie_pkg::ST_RUN)
        else $error("jump did not take two cycles");

    jump_pc_load_a: assert property (
        s_jump_taken |=> pc_reg == $past(addr_i))
        else $error("jump address not loaded");

    halt_flags_a: assert property (
        take && op_i == mie_pkg::OP_HALT |=> sleep_flag_o
        && !wdt_timeout_flag_o && wdt_clear_o && clk_stop_o)
        else $error("halt side effects missing");

    interrupt_exit_enable_a: assert property (
        take && op_i == mie_pkg::OP_INTERRUPT_EXIT |=> irq_enable_o
        && pc_reg == $past(stack_top_i))
        else $error("interrupt exit incomplete");

    no_skip_one_a: assert property (
        take && op_i == mie_pkg::OP_DSZ_M && !skip |=>
        state_reg == mie_pkg::ST_RUN)
        else $error("untaken skip stalled");

    skip_dummy_a: assert property (
        take && skip |=> state_reg == mie_pkg::ST_DUMMY
        && pc_reg == $past(pc_reg) + PC_W'(1) ##1
        pc_reg == $past(pc_reg, 2) + PC_W'(2))
        else $error("skip did not pass next instruction");

    ret_imm_acc_a: assert property (
        take && op_i == mie_pkg::OP_RET_AX |=> acc_reg == $past(imm_i)
        && flags_reg == $past(flags_reg))
        else $error("return immediate wrong");

    idle_flags_a: assert property (
        take && op_i == mie_pkg::OP_IDLE |=> acc_reg == $past(acc_reg)
        && flags_reg == $past(flags_reg) && !mem_we_o)
        else $error("idle changed state");

    acc_keep_mem_a: assert property (
        take && op_i == mie_pkg::OP_DSZ_A |=> !mem_we_o
        && acc_reg == $past(mem_rd_i) - mie_pkg::ONE)
        else $error("acc form wrote memory");

endmodule : mie_execute

// ==== sim/mie_execute_tb.sv ====
// self-checking bench for the instruction execute stage
`timescale 1ns/10ps
module mcu_instruction_execute_tb_top;
    // ****************************************************************
    // signals and reference state
    // ****************************************************************
    typedef struct packed {
        logic [7:0]               acc;
        logic [3:0]               flg;
        logic [mie_pkg::PC_W-1:0] pc;
        logic                     we;
        logic [7:0]               wd;
        logic                     busy;
        logic                     pop;
        logic                     ien;
        logic                     ent;
        logic                     slp;
    } mie_note_s;
    logic                     clk_i;
    logic                     rst_n_i;
    logic                     valid_i;
    mie_pkg::mie_op_e         op_i;
    logic [7:0]               imm_i;
    logic [7:0]               mem_rd_i;
    logic [mie_pkg::PC_W-1:0] addr_i;
    logic [mie_pkg::PC_W-1:0] stack_top_i;
    logic                     irq_pending_i;
    logic                     wake_i;
    logic [7:0]               acc_o;
    logic [3:0]               flags_o;
    logic [7:0]               mem_wd_o;
    logic [mie_pkg::PC_W-1:0] pc_o;
    logic                     mem_we_o, stack_pop_o, busy_o, irq_enable_o;
    logic                     irq_enter_o, sleep_flag_o, wdt_clear_o;
    logic                     wdt_timeout_flag_o, clk_stop_o;
    logic [31:0]              seed = 32'h0000004d;
    logic [7:0]               r_acc = 8'h00;
    logic [3:0]               r_flg = 4'h0;
    logic [mie_pkg::PC_W-1:0] r_pc = '0;
    logic                     r_ien = 1'b0;
    logic                     r_slp = 1'b0;
    mie_note_s                q[$];
    mie_note_s                e;
    int                       num_errors = 0;
    int                       n_tests = 0;
    int                       k;

    mie_execute #(.PC_W(mie_pkg::PC_W)) mie_execute_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .valid_i(valid_i), .op_i(op_i),
        .imm_i(imm_i), .addr_i(addr_i), .mem_rd_i(mem_rd_i),
        .stack_top_i(stack_top_i), .irq_pending_i(irq_pending_i),
        .wake_i(wake_i), .acc_o(acc_o), .flags_o(flags_o),
        .mem_wd_o(mem_wd_o), .mem_we_o(mem_we_o), .pc_o(pc_o),
        .stack_pop_o(stack_pop_o), .busy_o(busy_o),
        .irq_enable_o(irq_enable_o), .irq_enter_o(irq_enter_o),
        .sleep_flag_o(sleep_flag_o), .wdt_clear_o(wdt_clear_o),
        .wdt_timeout_flag_o(wdt_timeout_flag_o), .clk_stop_o(clk_stop_o));

    always #2 clk_i = ~clk_i;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic chk(input string nm, input logic [15:0] ex,
                       input logic [15:0] got);
        n_tests++;
        if (got !== ex)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // drives one op at a posedge step and notes what must follow it
    task automatic exec(input mie_pkg::mie_op_e op, input logic [7:0] m,
                        input logic [7:0] x);
        logic [7:0]               a, wd, dm, im, cr;
        logic [3:0]               f;
        logic [mie_pkg::PC_W-1:0] p, st;
        logic [8:0]               d, d2;
        logic [4:0]               h;
        logic                     c, w, sk, pop, ent, ov;
        mie_note_s                n;
        seed = xs(seed);
        st = seed[28:16];
        valid_i <= 1'b1;
        op_i <= op;
        mem_rd_i <= m;
        imm_i <= x;
        addr_i <= seed[12:0];
        stack_top_i <= st;
        irq_pending_i <= seed[31];
        {a, f, p, c} = {r_acc, r_flg, r_pc + 1'b1, r_flg[0]};
        {w, wd, sk, pop, ent} = '0;
        dm = m - 8'h01;
        im = m + 8'h01;
        cr = ((r_acc[3:0] > 4'h9 || r_flg[1]) ? 8'h06 : 8'h00)
           | ((r_acc[7:4] > 4'h9 || c) ? 8'h60 : 8'h00);
        d = {1'b0, r_acc} + {1'b0, cr};
        d2 = {1'b0, r_acc} - {1'b0, m} - {8'h00, ~c};
        h = {1'b0, r_acc[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
        ov = (r_acc[7] != m[7]) && (d2[7] != r_acc[7]);
        case (op)
            mie_pkg::OP_BCD_ADJ: {w, wd, f[0]} = {1'b1, d[7:0], d[8] | c};
            mie_pkg::OP_DEC_M:   {w, wd, f[2]} = {1'b1, dm, dm == 8'h00};
            mie_pkg::OP_DEC_A:   {a, f[2]} = {dm, dm == 8'h00};
            mie_pkg::OP_INC_M:   {w, wd, f[2]} = {1'b1, im, im == 8'h00};
            mie_pkg::OP_INC_A:   {a, f[2]} = {im, im == 8'h00};
            mie_pkg::OP_HALT:    {r_slp, p} = {1'b1, r_pc};
            mie_pkg::OP_JUMP:    {sk, p} = {1'b1, seed[12:0]};
            mie_pkg::OP_MOV_AM:  a = m;
            mie_pkg::OP_MOV_AX:  a = x;
            mie_pkg::OP_MOV_MA:  {w, wd} = {1'b1, r_acc};
            mie_pkg::OP_OR_AM:   {a, f[2]} = {r_acc | m, (r_acc | m) == 0};
            mie_pkg::OP_OR_AX:   {a, f[2]} = {r_acc | x, (r_acc | x) == 0};
            mie_pkg::OP_OR_MM:
                {w, wd, f[2]} = {1'b1, r_acc | m, (r_acc | m) == 0};
            mie_pkg::OP_RET:     {sk, p, pop} = {1'b1, st, 1'b1};
            mie_pkg::OP_RET_AX:  {sk, p, pop, a} = {1'b1, st, 1'b1, x};
            mie_pkg::OP_INTERRUPT_EXIT:
                {sk, p, pop, r_ien, ent} = {1'b1, st, 2'b11, seed[31]};
            mie_pkg::OP_ROL_M:   {w, wd} = {1'b1, m[6:0], m[7]};
            mie_pkg::OP_ROL_A:   a = {m[6:0], m[7]};
            mie_pkg::OP_ROLC_M:  {w, wd, f[0]} = {1'b1, m[6:0], c, m[7]};
            mie_pkg::OP_ROLC_A:  {a, f[0]} = {m[6:0], c, m[7]};
            mie_pkg::OP_ROR_M:   {w, wd} = {1'b1, m[0], m[7:1]};
            mie_pkg::OP_ROR_A:   a = {m[0], m[7:1]};
            mie_pkg::OP_RORC_M:  {w, wd, f[0]} = {1'b1, c, m[7:1], m[0]};
            mie_pkg::OP_RORC_A:  {a, f[0]} = {c, m[7:1], m[0]};
            mie_pkg::OP_SBC_A:
                {a, f} = {d2[7:0], ov, d2[7:0] == 0, ~h[4], ~d2[8]};
            mie_pkg::OP_SBC_M:
                {w, wd, f} = {1'b1, d2[7:0], ov, d2[7:0] == 0, ~h[4], ~d2[8]};
            mie_pkg::OP_DSZ_M:   {w, wd, sk} = {1'b1, dm, dm == 8'h00};
            mie_pkg::OP_DSZ_A:   {a, sk} = {dm, dm == 8'h00};
            default:             a = r_acc;
        endcase
        r_pc = p;
        if (sk && (op == mie_pkg::OP_DSZ_M || op == mie_pkg::OP_DSZ_A))
            r_pc = p + 1'b1;
        r_acc = a;
        r_flg = f;
        // halt also raises busy for one cycle
        n = '{a, f, p, w, wd, sk | (op == mie_pkg::OP_HALT), pop, r_ien,
              ent, r_slp};
        @(posedge clk_i);
        q.push_back(n);
        if (sk)
        begin
            // a copy offered in the dummy cycle must be refused
            op_i <= mie_pkg::OP_MOV_AX;
            imm_i <= ~x;
            @(posedge clk_i);
        end
    endtask : exec

    // ****************************************************************
    // monitor: oldest note against the settled outputs
    // ****************************************************************
    always @(negedge clk_i)
    begin
        if (q.size() > 0)
        begin
            e = q.pop_front();
            chk("acc", e.acc, acc_o);
            chk("flags", e.flg, flags_o);
            chk("pc", e.pc, pc_o);
            chk("mem_we", e.we, mem_we_o);
            if (e.we)
                chk("mem_wd", e.wd, mem_wd_o);
            chk("busy", e.busy, busy_o);
            chk("stack_pop", e.pop, stack_pop_o);
            chk("irq", {e.ien, e.ent},
                {irq_enable_o, irq_enter_o});
            chk("sleep", {e.slp, e.slp, 1'b0},
                {sleep_flag_o, clk_stop_o, wdt_timeout_flag_o});
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    localparam logic [7:0] BCD_V [4] = '{8'h45, 8'h3c, 8'hc3, 8'hab};
    initial
    begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        valid_i = 1'b0;
        op_i = mie_pkg::OP_IDLE;
        imm_i = 8'h00;
        mem_rd_i = 8'h00;
        addr_i = '0;
        stack_top_i = '0;
        irq_pending_i = 1'b0;
        wake_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        chk("rst", 16'h0000, {acc_o, flags_o, irq_enable_o, sleep_flag_o});
        chk("rst_pc", 16'h0000, pc_o);
        @(posedge clk_i);
        for (k = 0; k < 4; k++)
        begin
            exec(mie_pkg::OP_MOV_AX, 8'h00, BCD_V[k]);
            exec(mie_pkg::OP_BCD_ADJ, seed[7:0], 8'h00);
        end
        exec(mie_pkg::OP_DSZ_M, 8'h01, 8'h00);
        exec(mie_pkg::OP_DSZ_M, 8'h02, 8'h00);
        exec(mie_pkg::OP_DSZ_A, 8'h01, 8'h00);
        exec(mie_pkg::OP_DSZ_A, 8'h00, 8'h00);
        exec(mie_pkg::OP_IDLE, 8'hff, 8'hff);
        for (k = 0; k < 29; k++)
            if (k != 6)
                exec(mie_pkg::mie_op_e'(k), seed[23:16],
                     seed[15:8]);
        for (int i = 0; i < 400; i++)
        begin
            seed = xs(seed);
            k = seed[15:8] % 29;
            if (k == 6)
                k = 0;
            exec(mie_pkg::mie_op_e'(k), seed[23:16], seed[31:24]);
        end
        exec(mie_pkg::OP_HALT, 8'h00, 8'h00);
        op_i <= mie_pkg::OP_MOV_AX;
        imm_i <= ~r_acc;
        @(negedge clk_i);
        chk("wdt_clear", 16'h0001, wdt_clear_o);
        repeat (4) @(negedge clk_i);
        chk("acc_sleep", r_acc, acc_o);
        @(posedge clk_i);
        wake_i <= 1'b1;
        valid_i <= 1'b0;
        k = 0;
        while (clk_stop_o !== 1'b0 && k < 16)
        begin
            @(negedge clk_i);
            k++;
        end
        chk("wake", 16'h0000, clk_stop_o);
        finish_test();
    end
endmodule : mcu_instruction_execute_tb_top
